// ===== shared/srb_pkg.sv
// constants, opcodes and state encodings for the suspend/resume and block lock sequencer
package srb_pkg;
  // clock and latency timing (latencies are longest times, so counts round down)
  localparam int CLK_PERIOD_NS = 25;
  localparam int PROGRAM_SUSPEND_LATENCY_NS = 20000;
  localparam int ERASE_SUSPEND_LATENCY_NS = 20000;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] PSL_CYCLES = CNT_W'(PROGRAM_SUSPEND_LATENCY_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ESL_CYCLES = CNT_W'(ERASE_SUSPEND_LATENCY_NS / CLK_PERIOD_NS);

  // opcodes handled directly by this block
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_INDIVIDUAL_LOCK = 8'h36;

  // frame sizes in bits
  localparam logic [5:0] BITS_OPCODE = 6'h08;
  localparam logic [5:0] BITS_LOCK_3B = 6'h20;
  localparam logic [5:0] BITS_LOCK_4B = 6'h28;
  localparam logic [5:0] BITS_SAT = 6'h3F;

  // status word bit positions
  localparam int STAT_WIP = 0;
  localparam int STAT_WEL = 1;
  localparam int STAT_SUS = 15;

  // lock array layout: bottom and top 64KB blocks are sector granular
  localparam int LOCK_BITS = 544;
  localparam logic [8:0] BLK_BOTTOM = 9'h000;
  localparam logic [8:0] BLK_TOP = 9'h1FF;
  localparam logic [9:0] LOCK_TOP_BASE = 10'h010;
  localparam logic [9:0] LOCK_BLK_BASE = 10'h020;
  localparam logic [9:0] BLOCK_COUNT = 10'h200;
  localparam logic [4:0] BP_ALL = 5'h0A;

  // operation kinds reported by the array engine
  typedef enum logic [1:0] {
    SRB_KIND_PAGE = 2'h0,
    SRB_KIND_SECT4K = 2'h1,
    SRB_KIND_BLK32K = 2'h2,
    SRB_KIND_BLK64K = 2'h3
  } srb_kind_e;

  // command classes for acceptance while suspended
  typedef enum logic [1:0] {
    SRB_CLS_ANY = 2'h0,
    SRB_CLS_POST = 2'h1,
    SRB_CLS_ERASE_ONLY = 2'h2,
    SRB_CLS_OTHER = 2'h3
  } srb_cls_e;

  // sequencer states, gray coded along idle-busy-wait-suspended-nested
  typedef enum logic [2:0] {
    SRB_ST_IDLE = 3'h0,
    SRB_ST_BUSY = 3'h1,
    SRB_ST_SUSP_WAIT = 3'h3,
    SRB_ST_SUSPENDED = 3'h2,
    SRB_ST_NESTED_PGM = 3'h6
  } srb_state_e;
endpackage

// ===== core/srb_sync.sv
// two flip-flop synchroniser for pin inputs
module srb_sync #(
  parameter int W = 1
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage; reset leaves both low, idle levels set by caller after
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta <= '0;
      q_out <= '0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule

// ===== core/srb_core.sv
// program/erase suspend-resume sequencer with individual block locks
//
// Behaviour
// - suspend halts running program or erase
// - suspended region unreadable, rest readable
// - after latency clear latch, set flag
// - suspend flag at status bit 15
// - post-latency read/id/mode commands accepted
// - write-enable and page program only erase-suspended
// - status, reset, nop accepted any time
// - nested program only outside suspended erase region
// - nested program cannot be suspended
// - nested program holds latch and busy high
// - resume sets latch, busy; clears flag
// - nop only cancels armed reset
// - lock bits rule only when select set
// - lock bits come up set
// - lock command protects block or sector
// - lock needs chip select on byte boundary
module srb_core (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic addr_mode4_in,
  input wire logic protect_select_bit_in,
  input wire logic protect_complement_in,
  input wire logic [4:0] block_protect_bits_in,
  input wire logic op_start_in,
  input wire logic [1:0] op_kind_in,
  input wire logic [31:0] op_addr_in,
  input wire logic op_done_in,
  input wire logic [31:0] rd_addr_in,
  input wire logic [31:0] pgm_addr_in,
  output logic suspend_req_out,
  output logic soft_reset_out,
  output logic [7:0] opcode_out,
  output logic opcode_accept_out,
  output logic opcode_refuse_out,
  output logic read_allowed_out,
  output logic program_allowed_out,
  output logic write_enable_latch_out,
  output logic write_in_progress_out,
  output logic suspend_flag_out,
  output logic [15:0] status_word_out
);
  // pin synchronisers
  logic [2:0] pins_s;
  logic sclk_s;
  logic cs_n_s;
  logic si_s;
  logic sclk_prev;
  logic cs_n_prev;
  logic cs_seen;

  srb_sync #(.W(3)) u_sync (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .d_in({sclk_in, cs_n_in, si_in}),
    .q_out(pins_s)
  );

  // cs_seen masks the synchroniser's reset value until a real high chip select has been sampled
  assign sclk_s = pins_s[2];
  assign cs_n_s = pins_s[1] | ~cs_seen;
  assign si_s = pins_s[0];

  // frame state
  logic [5:0] bit_cnt;
  logic [31:0] shreg;
  logic [7:0] opcode;
  logic frame_ok;

  // sequencer state
  srb_pkg::srb_state_e state;
  logic [1:0] susp_kind;
  logic [31:0] susp_addr;
  logic [srb_pkg::CNT_W-1:0] lat_cnt;
  logic write_enable_latch;
  logic write_in_progress;
  logic suspend_flag;
  logic arm;
  logic [srb_pkg::LOCK_BITS-1:0] lock_bits;

  // classify an opcode for acceptance during suspend
  function automatic srb_pkg::srb_cls_e cmd_class(input logic [7:0] op);
    case (op)
      8'h04, 8'h05, 8'h35, 8'h15, 8'hAB, 8'h66, 8'h99, 8'h00: cmd_class = srb_pkg::SRB_CLS_ANY;
      8'h03, 8'h13, 8'h0B, 8'h0D, 8'h0C, 8'h3B, 8'h3C, 8'h6B, 8'hBB, 8'hBD, 8'hBC, 8'hEB, 8'hEC,
      8'hED, 8'hEE, 8'h38, 8'hFF, 8'h5A, 8'h9F, 8'hB7, 8'hE9, 8'h90, 8'h92, 8'h94, 8'h48, 8'hC0,
      8'h7A: cmd_class = srb_pkg::SRB_CLS_POST;
      8'h06, 8'h02, 8'h12, 8'hC2, 8'h3E: cmd_class = srb_pkg::SRB_CLS_ERASE_ONLY;
      default: cmd_class = srb_pkg::SRB_CLS_OTHER; // quad page program codes land here
    endcase
  endfunction

  // true when two addresses fall in the same page, sector or block of the given kind
  function automatic logic region_hit(input logic [1:0] kind, input logic [31:0] a, input logic [31:0] b);
    case (kind)
      srb_pkg::SRB_KIND_PAGE: region_hit = (a[31:8] == b[31:8]);
      srb_pkg::SRB_KIND_SECT4K: region_hit = (a[31:12] == b[31:12]);
      srb_pkg::SRB_KIND_BLK32K: region_hit = (a[31:15] == b[31:15]);
      default: region_hit = (a[31:16] == b[31:16]);
    endcase
  endfunction

  // lock bit index: edge blocks by 4KB sector, all others by 64KB block
  function automatic logic [9:0] lock_idx(input logic [31:0] a);
    if (a[24:16] == srb_pkg::BLK_BOTTOM) begin
      lock_idx = {6'h00, a[15:12]};
    end else if (a[24:16] == srb_pkg::BLK_TOP) begin
      lock_idx = srb_pkg::LOCK_TOP_BASE + {6'h00, a[15:12]};
    end else begin
      lock_idx = srb_pkg::LOCK_BLK_BASE + {1'b0, a[24:16]};
    end
  endfunction

  // protection of an address by lock bits or by the block-protect field
  function automatic logic is_protected(input logic [31:0] a, input logic [srb_pkg::LOCK_BITS-1:0] locks,
                                        input logic sel, input logic cmp, input logic [4:0] bp);
    logic [9:0] span;
    logic hit;
    span = 10'h000;
    hit = 1'b0;
    if (bp >= srb_pkg::BP_ALL) begin
      span = srb_pkg::BLOCK_COUNT;
    end else if (bp != 5'h00) begin
      span = 10'h001 << (bp - 5'h01);
    end
    hit = (span != 10'h000) && ({1'b0, a[24:16]} >= (srb_pkg::BLOCK_COUNT - span));
    if (sel) begin
      is_protected = locks[lock_idx(a)];
    end else begin
      is_protected = hit ^ cmp;
    end
  endfunction

  // edge detection on the synchronised link
  wire sclk_rise = sclk_s & ~sclk_prev;
  wire cs_fall = ~cs_n_s & cs_n_prev;
  wire cs_rise = cs_n_s & ~cs_n_prev;
  wire bit_take = sclk_rise & ~cs_n_s;
  wire [7:0] opcode_now = {shreg[6:0], si_s};
  wire opcode_done = bit_take & (bit_cnt == srb_pkg::BITS_OPCODE - 6'h01);
  wire [31:0] frame_addr = addr_mode4_in ? shreg : {8'h00, shreg[23:0]};
  wire [5:0] lock_bits_need = addr_mode4_in ? srb_pkg::BITS_LOCK_4B : srb_pkg::BITS_LOCK_3B;

  // acceptance of the incoming opcode in the present state
  srb_pkg::srb_cls_e cls_now;
  logic accept_now;
  wire erase_susp = (susp_kind != srb_pkg::SRB_KIND_PAGE);
  assign cls_now = cmd_class(opcode_now);
  always_comb begin
    case (state)
      srb_pkg::SRB_ST_IDLE: accept_now = 1'b1;
      srb_pkg::SRB_ST_BUSY: accept_now = (cls_now == srb_pkg::SRB_CLS_ANY) || (opcode_now == srb_pkg::OP_SUSPEND);
      srb_pkg::SRB_ST_SUSP_WAIT: accept_now = (cls_now == srb_pkg::SRB_CLS_ANY);
      srb_pkg::SRB_ST_SUSPENDED: accept_now = (cls_now == srb_pkg::SRB_CLS_ANY)
                                            || (cls_now == srb_pkg::SRB_CLS_POST)
                                            || ((cls_now == srb_pkg::SRB_CLS_ERASE_ONLY) && erase_susp);
      srb_pkg::SRB_ST_NESTED_PGM: accept_now = (cls_now == srb_pkg::SRB_CLS_ANY);
      default: accept_now = 1'b0;
    endcase
  end

  // frame-end decode: single-byte commands need exactly eight bits
  wire frame_end = cs_rise & frame_ok;
  wire one_byte = (bit_cnt == srb_pkg::BITS_OPCODE);
  wire do_suspend = frame_end & one_byte & (opcode == srb_pkg::OP_SUSPEND);
  wire do_resume = frame_end & one_byte & (opcode == srb_pkg::OP_RESUME);
  wire do_write_enable_cmd = frame_end & one_byte & (opcode == srb_pkg::OP_WRITE_ENABLE);
  wire do_write_disable_cmd = frame_end & one_byte & (opcode == srb_pkg::OP_WRITE_DISABLE);
  wire do_arm = frame_end & one_byte & (opcode == srb_pkg::OP_RESET_ARM);
  wire do_reset = frame_end & one_byte & (opcode == srb_pkg::OP_RESET) & arm;
  // lock frame must end on the byte boundary after the full address, with the latch set
  wire do_lock = frame_end & (opcode == srb_pkg::OP_INDIVIDUAL_LOCK) & (bit_cnt == lock_bits_need)
                 & write_enable_latch & (state == srb_pkg::SRB_ST_IDLE);
  wire lat_done = (state == srb_pkg::SRB_ST_SUSP_WAIT) && (lat_cnt == '0);

  // next values of the sequencer
  srb_pkg::srb_state_e next_state;
  logic [srb_pkg::CNT_W-1:0] next_lat_cnt;
  logic next_wel;
  logic next_wip;
  logic next_sus;
  logic next_req;
  always_comb begin
    next_state = state;
    next_lat_cnt = (lat_cnt != '0) ? lat_cnt - 1'b1 : lat_cnt;
    next_wel = write_enable_latch;
    next_wip = write_in_progress;
    next_sus = suspend_flag;
    next_req = suspend_req_out;
    case (state)
      srb_pkg::SRB_ST_IDLE: begin
        if (op_start_in) begin
          next_state = srb_pkg::SRB_ST_BUSY;
          next_wip = 1'b1;
        end
      end
      srb_pkg::SRB_ST_BUSY: begin
        if (op_done_in) begin
          next_state = srb_pkg::SRB_ST_IDLE;
          next_wel = 1'b0;
          next_wip = 1'b0;
        end else if (do_suspend) begin
          next_state = srb_pkg::SRB_ST_SUSP_WAIT;
          next_req = 1'b1;
          next_lat_cnt = (susp_kind == srb_pkg::SRB_KIND_PAGE) ? srb_pkg::PSL_CYCLES : srb_pkg::ESL_CYCLES;
        end
      end
      srb_pkg::SRB_ST_SUSP_WAIT: begin
        if (op_done_in) begin
          // operation finished before it could halt: nothing left to suspend
          next_state = srb_pkg::SRB_ST_IDLE;
          next_req = 1'b0;
          next_wel = 1'b0;
          next_wip = 1'b0;
        end else if (lat_done) begin
          next_state = srb_pkg::SRB_ST_SUSPENDED;
          next_wel = 1'b0;
          next_wip = 1'b0;
          next_sus = 1'b1;
        end
      end
      srb_pkg::SRB_ST_SUSPENDED: begin
        if (do_resume) begin
          next_state = srb_pkg::SRB_ST_BUSY;
          next_req = 1'b0;
          next_wel = 1'b1;
          next_wip = 1'b1;
          next_sus = 1'b0;
        end else if (op_start_in && erase_susp && (op_kind_in == srb_pkg::SRB_KIND_PAGE)) begin
          next_state = srb_pkg::SRB_ST_NESTED_PGM;
          next_wel = 1'b1;
          next_wip = 1'b1;
        end
      end
      srb_pkg::SRB_ST_NESTED_PGM: begin
        // suspend is not decoded here, so the nested program runs out unless a soft reset aborts it
        if (op_done_in) begin
          next_state = srb_pkg::SRB_ST_SUSPENDED;
          next_wel = 1'b0;
          next_wip = 1'b0;
        end
      end
      default: next_state = srb_pkg::SRB_ST_IDLE;
    endcase
    // latch commands are applied after the case so they win over the implicit updates above; only soft reset follows them
    if (do_write_enable_cmd) begin
      next_wel = 1'b1;
    end
    // a nested program keeps its latch up until it completes, so write-disable is ignored during it
    if ((do_write_disable_cmd && (state != srb_pkg::SRB_ST_NESTED_PGM)) || do_lock) begin
      next_wel = 1'b0;
    end
    if (do_reset) begin
      // soft reset aborts everything and returns to power-on values
      next_state = srb_pkg::SRB_ST_IDLE;
      next_lat_cnt = '0;
      next_wel = 1'b0;
      next_wip = 1'b0;
      next_sus = 1'b0;
      next_req = 1'b0;
    end
  end

  // link edge history and the chip-select-seen flag
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_prev <= 1'b0;
      cs_n_prev <= 1'b1;
      cs_seen <= 1'b0;
    end else begin
      sclk_prev <= sclk_s;
      cs_n_prev <= cs_n_s;
      cs_seen <= cs_seen | pins_s[1];
    end
  end

  // bit counter saturates so an over-long frame can never alias a legal length
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bit_cnt <= '0;
      shreg <= '0;
    end else if (cs_fall) begin
      bit_cnt <= '0;
      shreg <= '0;
    end else if (bit_take) begin
      bit_cnt <= (bit_cnt == srb_pkg::BITS_SAT) ? bit_cnt : bit_cnt + 6'h01;
      shreg <= (bit_cnt < srb_pkg::BITS_OPCODE) ? {24'h000000, opcode_now} : {shreg[30:0], si_s};
    end
  end

  // opcode capture and accept/refuse pulses after the eighth bit
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      opcode <= srb_pkg::OP_NOP;
      frame_ok <= 1'b0;
      opcode_accept_out <= 1'b0;
      opcode_refuse_out <= 1'b0;
    end else begin
      opcode_accept_out <= opcode_done & accept_now;
      opcode_refuse_out <= opcode_done & ~accept_now;
      if (cs_fall) begin
        frame_ok <= 1'b0;
      end else if (opcode_done) begin
        opcode <= opcode_now;
        frame_ok <= accept_now;
      end
    end
  end
  assign opcode_out = opcode;

  // sequencer registers
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= srb_pkg::SRB_ST_IDLE;
      lat_cnt <= '0;
      write_enable_latch <= 1'b0;
      write_in_progress <= 1'b0;
      suspend_flag <= 1'b0;
      suspend_req_out <= 1'b0;
    end else begin
      state <= next_state;
      lat_cnt <= next_lat_cnt;
      write_enable_latch <= next_wel;
      write_in_progress <= next_wip;
      suspend_flag <= next_sus;
      suspend_req_out <= next_req;
    end
  end

  // the suspended operation's kind and address, kept through a nested program
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      susp_kind <= srb_pkg::SRB_KIND_PAGE;
      susp_addr <= '0;
    end else if (op_start_in && (state == srb_pkg::SRB_ST_IDLE)) begin
      susp_kind <= op_kind_in;
      susp_addr <= op_addr_in;
    end
  end

  // reset arm: any accepted frame other than the arm itself cancels it, nop included
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      arm <= 1'b0;
    end else if (frame_end) begin
      arm <= do_arm;
    end
  end

  // lock bits are volatile and start fully set
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lock_bits <= '1;
    end else if (do_reset) begin
      lock_bits <= '1;
    end else if (do_lock) begin
      lock_bits[lock_idx(frame_addr)] <= 1'b1;
    end
  end

  // address checks; reads barred only in a held-off region, programs also where protected, and in the suspended region while in SRB_ST_SUSPENDED
  wire held = (state == srb_pkg::SRB_ST_SUSPENDED) || (state == srb_pkg::SRB_ST_NESTED_PGM);
  wire rd_ok = !(held && region_hit(susp_kind, susp_addr, rd_addr_in));
  wire pgm_ok = !is_protected(pgm_addr_in, lock_bits, protect_select_bit_in, protect_complement_in,
                              block_protect_bits_in)
                && !((state == srb_pkg::SRB_ST_SUSPENDED) && region_hit(susp_kind, susp_addr, pgm_addr_in));
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      read_allowed_out <= 1'b0;
      program_allowed_out <= 1'b0;
      soft_reset_out <= 1'b0;
    end else begin
      read_allowed_out <= rd_ok;
      program_allowed_out <= pgm_ok;
      soft_reset_out <= do_reset;
    end
  end

  // status outputs: suspend flag sits at bit 15
  assign write_enable_latch_out = write_enable_latch;
  assign write_in_progress_out = write_in_progress;
  assign suspend_flag_out = suspend_flag;
  assign status_word_out = {suspend_flag, 13'h0000, write_enable_latch, write_in_progress};
endmodule

// ===== tb/srb_host_model.sv
// serial host model that frames commands on chip select, serial clock and data
module srb_host_model (
  input wire logic mclk_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic si_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // the serial clock stands still low between frames
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end

  // mode 0 frame, msb first; 8 mclk per serial clock period
  // a count that is not a whole number of bytes breaks the byte boundary on purpose
  task automatic send(input logic [39:0] bits, input int count);
    @(posedge mclk_in);
    cs_n_out <= 1'b0;
    for (int i = 0; i < count; i++) begin
      si_out <= bits[39 - i];
      repeat (4) @(posedge mclk_in);
      sclk_out <= 1'b1;
      repeat (4) @(posedge mclk_in);
      sclk_out <= 1'b0;
    end
    @(posedge mclk_in);
    cs_n_out <= 1'b1;
    si_out <= ~si_out; // released line shows no stale bit
    repeat (12) @(posedge mclk_in);
  endtask
endmodule

// ===== tb/srb_monitor.sv
// assertion checker for the suspend/resume sequencer ports
module srb_monitor (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic suspend_req_out,
  input wire logic soft_reset_out,
  input wire logic opcode_accept_out,
  input wire logic opcode_refuse_out,
  input wire logic write_enable_latch_out,
  input wire logic write_in_progress_out,
  input wire logic suspend_flag_out,
  input wire logic [15:0] status_word_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] wait_cnt;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  // cycles with the halt request up; saturates so a long suspend cannot wrap
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) wait_cnt <= 12'h000;
    else if (!suspend_req_out) wait_cnt <= 12'h000;
    else if (wait_cnt != 12'hFFF) wait_cnt <= wait_cnt + 12'h001;
  end

  a_status_map: assert property (status_word_out ==
    {suspend_flag_out, 13'h0000, write_enable_latch_out, write_in_progress_out}) else $error("status word mismatch");
  a_flag_clears_latch: assert property ($rose(suspend_flag_out) |->
    !write_enable_latch_out && !write_in_progress_out) else $error("latch not cleared at suspend");
  a_suspend_latency: assert property ($rose(suspend_flag_out) |->
    wait_cnt >= 12'h31E && wait_cnt <= 12'h322) else $error("suspend latency wrong");
  a_suspend_bound: assert property ($rose(suspend_req_out) |->
    ##[1:900] (suspend_flag_out || !suspend_req_out)) else $error("suspend never completed");
  a_req_cause: assert property ($rose(suspend_req_out) |->
    $past(write_in_progress_out) && !suspend_flag_out) else $error("halt request without running operation");
  a_resume_sets: assert property ($fell(suspend_flag_out) && !soft_reset_out && !$past(soft_reset_out) |->
    write_enable_latch_out && write_in_progress_out && !suspend_req_out) else $error("resume flags wrong");
  a_nested_latch: assert property (suspend_flag_out && write_in_progress_out |->
    write_enable_latch_out) else $error("nested program without latch");
  a_answer_once: assert property (opcode_accept_out || opcode_refuse_out |->
    !(opcode_accept_out && opcode_refuse_out) ##1 !(opcode_accept_out || opcode_refuse_out))
    else $error("opcode answer malformed");

  c_suspended: cover property ($rose(suspend_flag_out));
  c_nested: cover property (suspend_flag_out && write_in_progress_out);
  c_resumed: cover property ($fell(suspend_flag_out));
endmodule

bind srb_core srb_monitor srb_monitor_i (.mclk_in, .nrst_in, .suspend_req_out, .soft_reset_out, .opcode_accept_out,
  .opcode_refuse_out, .write_enable_latch_out, .write_in_progress_out, .suspend_flag_out, .status_word_out);

// ===== tb/srb_core_tb.sv
// self-checking bench for the suspend/resume and block lock sequencer
module srb_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in, nrst_in, sclk, cs_n, si, psel, op_start, op_done, am4, cmp;
  logic [7:0] opc;
  logic req, srst, acc, rfs, rd_ok, pg_ok, write_enable_latch, write_in_progress, suspend_flag;
  logic [4:0] bp;
  logic [1:0] op_kind;
  logic [31:0] op_addr, rd_addr, pg_addr;
  logic [15:0] stat;
  int errors, checked, n_acc, n_rst, n_rfs;
  localparam int RESUME_GAP = 40; // host gap between resume and the next suspend, a plain default

  srb_core srb_core_i (.mclk_in, .nrst_in, .sclk_in(sclk), .cs_n_in(cs_n), .si_in(si), .addr_mode4_in(am4),
    .protect_select_bit_in(psel), .protect_complement_in(cmp), .block_protect_bits_in(bp), .op_start_in(op_start),
    .op_kind_in(op_kind), .op_addr_in(op_addr), .op_done_in(op_done), .rd_addr_in(rd_addr), .pgm_addr_in(pg_addr),
    .suspend_req_out(req), .soft_reset_out(srst), .opcode_out(opc), .opcode_accept_out(acc),
    .opcode_refuse_out(rfs), .read_allowed_out(rd_ok), .program_allowed_out(pg_ok),
    .write_enable_latch_out(write_enable_latch), .write_in_progress_out(write_in_progress), .suspend_flag_out(suspend_flag), .status_word_out(stat));
  srb_host_model srb_host_model_i (.mclk_in, .sclk_out(sclk), .cs_n_out(cs_n), .si_out(si));

  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end

  // pulses are tallied so frame tasks can judge them after the frame
  always @(posedge mclk_in) begin
    if (acc === 1'b1) n_acc++;
    if (srst === 1'b1) n_rst++;
    if (rfs === 1'b1) n_rfs++;
  end

  task automatic check_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %b", $time, what, got);
    end
  endtask

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op, input logic exp);
    int a;
    int r;
    a = n_acc;
    r = n_rfs;
    srb_host_model_i.send({op, 32'h0000_0000}, 8);
    check_bit(n_acc == a + 1, exp, "opcode answer");
    check_bit(n_rfs == r + 1, ~exp, "opcode refusal");
    check_word({8'h00, opc}, {8'h00, op}, "captured opcode");
  endtask

  // engine start (s=1) or done (s=0) pulse, then let flags settle
  task automatic op_pulse(input logic s, input logic [1:0] k, input logic [31:0] a);
    @(posedge mclk_in);
    op_kind <= k;
    op_addr <= a;
    op_start <= s;
    op_done <= ~s;
    @(posedge mclk_in);
    op_start <= 1'b0;
    op_done <= 1'b0;
    repeat (3) @(posedge mclk_in);
  endtask

  task automatic prot(input logic sel, input logic [4:0] b, input logic c);
    @(posedge mclk_in);
    psel <= sel;
    bp <= b;
    cmp <= c;
  endtask

  task automatic probe(input logic [31:0] a, input logic er, input logic ep);
    @(posedge mclk_in);
    rd_addr <= a;
    pg_addr <= a;
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
    check_bit(rd_ok, er, "read permit");
    check_bit(pg_ok, ep, "program permit");
  endtask

  task automatic flags(input logic [15:0] e);
    @(negedge mclk_in);
    check_word(stat, e, "status word");
    check_word({suspend_flag, 13'h0000, write_enable_latch, write_in_progress}, e, "flag ports");
  endtask

  // bounded wait; the latency is 800 cycles
  task automatic wait_flag();
    int i;
    for (i = 0; i < 1000 && suspend_flag !== 1'b1; i++) @(posedge mclk_in);
    if (i == 1000) begin
      errors++;
      $display("unexpected at %0t: suspend flag never set", $time);
      stop_test();
    end
  endtask

  task automatic t_reset();
    flags(16'h0000);
    probe(32'h0040_0000, 1'b1, 1'b0);
    prot(1'b0, 5'h00, 1'b0);
    probe(32'h0040_0000, 1'b1, 1'b1);
    prot(1'b0, 5'h00, 1'b1);
    probe(32'h0040_0000, 1'b1, 1'b0);
    prot(1'b0, srb_pkg::BP_ALL, 1'b0);
    probe(32'h0040_0000, 1'b1, 1'b0);
    cmd(8'h75, 1'b1);
    flags(16'h0000);
    check_bit(req, 1'b0, "halt request");
    $display("reset and idle test done");
  endtask

  task automatic t_erase();
    prot(1'b0, 5'h00, 1'b0);
    op_pulse(1'b1, 2'h1, 32'h0012_3000);
    check_bit(write_in_progress, 1'b1, "busy");
    cmd(8'h75, 1'b1);
    check_bit(req, 1'b1, "halt request");
    cmd(8'h05, 1'b1);
    cmd(8'h03, 1'b0);
    repeat (400) @(posedge mclk_in);
    check_bit(suspend_flag, 1'b0, "flag before latency");
    wait_flag();
    flags(16'h8000);
    probe(32'h0012_3ABC, 1'b0, 1'b0);
    probe(32'h0012_4000, 1'b1, 1'b1);
    probe(32'h0012_2FFF, 1'b1, 1'b1);
    cmd(8'h03, 1'b1);
    cmd(8'h9F, 1'b1);
    cmd(8'h32, 1'b0);
    cmd(8'hC2, 1'b1);
    cmd(8'h06, 1'b1);
    flags(16'h8002);
    op_pulse(1'b1, 2'h0, 32'h0012_4000);
    flags(16'h8003);
    cmd(8'h75, 1'b0);
    flags(16'h8003);
    op_pulse(1'b0, 2'h0, 32'h0012_4000);
    flags(16'h8000);
    cmd(8'h7A, 1'b1);
    flags(16'h0003);
    check_bit(req, 1'b0, "halt request");
    repeat (RESUME_GAP) @(posedge mclk_in);
    cmd(8'h75, 1'b1);
    check_bit(req, 1'b1, "halt request");
    op_pulse(1'b0, 2'h1, 32'h0012_3000);
    flags(16'h0000);
    check_bit(req, 1'b0, "halt request");
    $display("erase suspend test done");
  endtask

  task automatic t_program();
    prot(1'b1, 5'h00, 1'b0);
    op_pulse(1'b1, 2'h0, 32'h0000_0100);
    cmd(8'h75, 1'b1);
    wait_flag();
    flags(16'h8000);
    probe(32'h0000_01FF, 1'b0, 1'b0);
    probe(32'h0000_0200, 1'b1, 1'b0);
    cmd(8'h06, 1'b0);
    cmd(8'hC2, 1'b0);
    cmd(8'hEB, 1'b1);
    cmd(8'h7A, 1'b1);
    flags(16'h0003);
    op_pulse(1'b0, 2'h0, 32'h0000_0100);
    $display("program suspend test done");
  endtask

  task automatic t_arm_lock();
    int r;
    r = n_rst;
    cmd(8'h66, 1'b1);
    cmd(8'h00, 1'b1);
    cmd(8'h99, 1'b1);
    check_bit(n_rst == r, 1'b1, "no soft reset");
    cmd(8'h66, 1'b1);
    cmd(8'h99, 1'b1);
    check_bit(n_rst == r + 1, 1'b1, "soft reset");
    cmd(8'h06, 1'b1);
    flags(16'h0002);
    srb_host_model_i.send({8'h36, 32'h1230_0000}, 31);
    flags(16'h0002);
    srb_host_model_i.send({8'h36, 32'h1230_0000}, 32);
    flags(16'h0000);
    @(posedge mclk_in);
    am4 <= 1'b1;
    cmd(8'h06, 1'b1);
    srb_host_model_i.send({8'h36, 32'h0123_0000}, 32);
    flags(16'h0002);
    srb_host_model_i.send({8'h36, 32'h0123_0000}, 40);
    flags(16'h0000);
    $display("reset arm and lock test done");
  endtask

  initial begin
    nrst_in = 1'b0;
    psel = 1'b1;
    bp = 5'h00;
    cmp = 1'b0;
    am4 = 1'b0;
    op_start = 1'b0;
    op_done = 1'b0;
    op_kind = 2'h0;
    op_addr = 32'h0000_0000;
    rd_addr = 32'h0000_0000;
    pg_addr = 32'h0000_0000;
    repeat (10) @(posedge mclk_in);
    nrst_in <= 1'b1;
    repeat (6) @(posedge mclk_in);
    t_reset();
    t_erase();
    t_program();
    t_arm_lock();
    stop_test();
  end
endmodule
